// ---- hw/adc_test_consts.svh ----
`ifndef ADC_TEST_CONSTS_SVH
`define ADC_TEST_CONSTS_SVH
`define ADDR_LINK_PLL_STATUS 8'h0A
`define ADDR_ENCODE_CLOCK_DIVIDER 8'h0B
`define ADDR_OUTPUT_TEST_CONTROL 8'h0D
`define RESET_ENCODE_CLOCK_DIVIDER 8'h00
`define RESET_OUTPUT_TEST_CONTROL 8'h00
`define SAMPLE_WIDTH 11
`define TEST_MODE_LSB 0
`define TEST_MODE_MSB 3
`define SHORT_RESET_BIT 4
`define LONG_RESET_BIT 5
`define USER_SINGLE_BIT 7
`define STATUS_LOCK_BIT 7
`define STATUS_READY_BIT 0
`define DIV_RATIO_MSB 2
`define CODE_MIDSCALE 11'h000
`define CODE_POS_FULL 11'h3FF
`define CODE_NEG_FULL 11'h400
`define CODE_CHECK_A 11'h555
`define CODE_CHECK_B 11'h2AA
`define CODE_ONES 11'h7FF
`define CODE_ZEROS 11'h000
`define LONG_NOISE_LEN 23
`define LONG_NOISE_TAP 18
`define SHORT_NOISE_LEN 9
`define SHORT_NOISE_TAP 5
`endif

// ---- hw/adc_test_pkg.sv ----
`include "adc_test_consts.svh"
package adc_test_pkg;
	typedef logic [`SAMPLE_WIDTH-1:0] sample_type;
	typedef enum logic [3:0] {
		MODE_OFF = 4'h0,
		MODE_MIDSCALE = 4'h1,
		MODE_POS_FULL = 4'h2,
		MODE_NEG_FULL = 4'h3,
		MODE_CHECKER = 4'h4,
		MODE_NOISE_LONG = 4'h5,
		MODE_NOISE_SHORT = 4'h6,
		MODE_WORD_TOGGLE = 4'h7,
		MODE_USER = 4'h8,
		MODE_RAMP = 4'hF
	} test_mode_type;
	typedef enum logic [2:0] {
		USER_WORD1 = 3'h0,
		USER_WORD2 = 3'h1,
		USER_WORD3 = 3'h3,
		USER_WORD4 = 3'h2,
		USER_DONE = 3'h6
	} user_state_type;
endpackage

// ---- hw/pseudo_noise_sequence.sv ----
`include "adc_test_consts.svh"
module pseudo_noise_sequence #(
	parameter int LEN = 9,
	parameter int TAP = 5
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// control
	input wire logic hold_i,
	input wire logic step_i,
	// state
	output logic [LEN-1:0] state_o
);
	logic [LEN-1:0] state_reg;
	logic [LEN-1:0] state_next;

	always_comb begin
		state_next = state_reg;
		// all-ones seed; all-zeros would lock the shift register
		if (hold_i) begin
			state_next = '1;
		end else if (step_i) begin
			state_next = {state_reg[LEN-2:0], state_reg[LEN-1] ^ state_reg[TAP-1]};
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_reg <= '1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign state_o = state_reg;
endmodule

// ---- hw/adc_test_pattern_and_status_regs.sv ----
`include "adc_test_consts.svh"
module adc_test_pattern_and_status_regs
	import adc_test_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// serial control port register access
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_write_i,
	output logic [7:0] reg_rdata_o,
	// status sources
	input wire logic pll_locked_i,
	input wire logic link_ready_i,
	// converter samples, two channels
	input wire logic sample_valid_i,
	input wire logic [1:0][`SAMPLE_WIDTH-1:0] adc_i,
	// user pattern words
	input wire logic [`SAMPLE_WIDTH-1:0] user_pattern1_i,
	input wire logic [`SAMPLE_WIDTH-1:0] user_pattern2_i,
	input wire logic [`SAMPLE_WIDTH-1:0] user_pattern3_i,
	input wire logic [`SAMPLE_WIDTH-1:0] user_pattern4_i,
	// output samples
	output logic out_valid_o,
	output logic [1:0][`SAMPLE_WIDTH-1:0] out_o,
	// clock divider
	output logic [7:0] divider_ratio_o,
	output logic div_tick_o
);
	logic [7:0] div_reg;
	logic [7:0] div_next;
	logic [7:0] test_reg;
	logic [7:0] test_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [2:0] cnt_reg;
	logic [2:0] cnt_next;
	logic toggle_reg;
	logic toggle_next;
	sample_type ramp_reg;
	sample_type ramp_next;
	user_state_type user_reg;
	user_state_type user_next;
	logic out_valid_reg;
	logic out_valid_next;
	logic [1:0][`SAMPLE_WIDTH-1:0] out_reg;
	logic [1:0][`SAMPLE_WIDTH-1:0] out_next;
	logic [`LONG_NOISE_LEN-1:0] long_state;
	logic [`SHORT_NOISE_LEN-1:0] short_state;
	logic [3:0] mode;
	sample_type pattern;
	sample_type user_word;

	assign mode = test_reg[`TEST_MODE_MSB:`TEST_MODE_LSB];

	// register bank
	always_comb begin
		div_next = div_reg;
		test_next = test_reg;
		rdata_next = 8'h00;
		if (reg_write_i && reg_addr_i == `ADDR_ENCODE_CLOCK_DIVIDER) begin
			div_next = reg_wdata_i;
		end
		if (reg_write_i && reg_addr_i == `ADDR_OUTPUT_TEST_CONTROL) begin
			test_next = reg_wdata_i;
		end
		case (reg_addr_i)
			`ADDR_LINK_PLL_STATUS: begin
				rdata_next[`STATUS_LOCK_BIT] = pll_locked_i;
				rdata_next[`STATUS_READY_BIT] = link_ready_i;
			end
			`ADDR_ENCODE_CLOCK_DIVIDER: rdata_next = div_reg;
			`ADDR_OUTPUT_TEST_CONTROL: rdata_next = test_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			div_reg <= `RESET_ENCODE_CLOCK_DIVIDER;
			test_reg <= `RESET_OUTPUT_TEST_CONTROL;
			rdata_reg <= 8'h00;
		end else begin
			div_reg <= div_next;
			test_reg <= test_next;
			rdata_reg <= rdata_next;
		end
	end

	// divider: only three ratio bits matter, upper bits are stored but unused
	always_comb begin
		cnt_next = cnt_reg + 3'h1;
		if (cnt_reg >= div_reg[`DIV_RATIO_MSB:0]) begin
			cnt_next = 3'h0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			cnt_reg <= 3'h0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign div_tick_o = (cnt_reg >= div_reg[`DIV_RATIO_MSB:0]);
	assign divider_ratio_o = div_reg;

	// pseudo-random generators, held while their reset bits are set
	pseudo_noise_sequence #(
		.LEN(`LONG_NOISE_LEN),
		.TAP(`LONG_NOISE_TAP)
	) pseudo_random_generator_long (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.hold_i(test_reg[`LONG_RESET_BIT]),
		.step_i(sample_valid_i),
		.state_o(long_state)
	);

	pseudo_noise_sequence #(
		.LEN(`SHORT_NOISE_LEN),
		.TAP(`SHORT_NOISE_TAP)
	) pseudo_random_generator_short (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.hold_i(test_reg[`SHORT_RESET_BIT]),
		.step_i(sample_valid_i),
		.state_o(short_state)
	);

	// pattern sequencing state
	always_comb begin
		toggle_next = toggle_reg;
		ramp_next = ramp_reg;
		user_next = user_reg;
		if (sample_valid_i) begin
			toggle_next = ~toggle_reg;
			ramp_next = ramp_reg + 11'h001;
			case (user_reg)
				USER_WORD1: user_next = USER_WORD2;
				USER_WORD2: user_next = USER_WORD3;
				USER_WORD3: user_next = USER_WORD4;
				USER_WORD4: user_next = test_reg[`USER_SINGLE_BIT] ? USER_DONE : USER_WORD1;
				USER_DONE: user_next = USER_DONE;
				default: user_next = USER_WORD1;
			endcase
		end
		// leaving user mode rearms the sequence at word 1
		if (mode != MODE_USER) begin
			user_next = USER_WORD1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			toggle_reg <= 1'b0;
			ramp_reg <= 11'h000;
			user_reg <= USER_WORD1;
		end else begin
			toggle_reg <= toggle_next;
			ramp_reg <= ramp_next;
			user_reg <= user_next;
		end
	end

	always_comb begin
		case (user_reg)
			USER_WORD1: user_word = user_pattern1_i;
			USER_WORD2: user_word = user_pattern2_i;
			USER_WORD3: user_word = user_pattern3_i;
			USER_WORD4: user_word = user_pattern4_i;
			default: user_word = `CODE_ZEROS;
		endcase
	end

	always_comb begin
		case (mode)
			MODE_MIDSCALE: pattern = `CODE_MIDSCALE;
			MODE_POS_FULL: pattern = `CODE_POS_FULL;
			MODE_NEG_FULL: pattern = `CODE_NEG_FULL;
			MODE_CHECKER: pattern = toggle_reg ? `CODE_CHECK_B : `CODE_CHECK_A;
			MODE_NOISE_LONG: pattern = long_state[`SAMPLE_WIDTH-1:0];
			MODE_NOISE_SHORT: pattern = {2'h0, short_state};
			MODE_WORD_TOGGLE: pattern = toggle_reg ? `CODE_ZEROS : `CODE_ONES;
			MODE_USER: pattern = user_word;
			MODE_RAMP: pattern = ramp_reg;
			default: pattern = `CODE_ZEROS;
		endcase
	end

	// output stage, one register per channel
	assign out_valid_next = sample_valid_i;
	generate
		for (genvar ch = 0; ch < 2; ch++) begin : g_chan
			always_comb begin
				out_next[ch] = out_reg[ch];
				if (sample_valid_i) begin
					out_next[ch] = (mode == MODE_OFF) ? adc_i[ch] : pattern;
				end
			end

			always_ff @(posedge sys_clk_i) begin
				if (rst_i) begin
					out_reg[ch] <= `CODE_ZEROS;
				end else begin
					out_reg[ch] <= out_next[ch];
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			out_valid_reg <= 1'b0;
		end else begin
			out_valid_reg <= out_valid_next;
		end
	end

	assign out_valid_o = out_valid_reg;
	assign out_o = out_reg;
	assign reg_rdata_o = rdata_reg;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	sequence two_samples_in(logic [3:0] m);
		(sample_valid_i && mode == m) ##1 (sample_valid_i && mode == m);
	endsequence

	normal_pass_a: assert property (
		sample_valid_i && mode == MODE_OFF |=> out_o[1] == $past(adc_i[1])
	) else $error("normal mode did not pass samples");
	midscale_out_a: assert property (
		sample_valid_i && mode == MODE_MIDSCALE |=> out_o[0] == 11'h000
	) else $error("midscale code wrong");
	pos_full_a: assert property (
		sample_valid_i && mode == MODE_POS_FULL |=> out_o[0] == 11'h3FF
	) else $error("positive full scale code wrong");
	neg_full_a: assert property (
		sample_valid_i && mode == MODE_NEG_FULL |=> out_o[1] == 11'h400
	) else $error("negative full scale code wrong");
	checker_invert_a: assert property (
		two_samples_in(MODE_CHECKER) |=> out_o[0] == ~$past(out_o[0])
			&& out_o[0][0] != out_o[0][1]
	) else $error("checkerboard did not invert");
	word_toggle_a: assert property (
		two_samples_in(MODE_WORD_TOGGLE) |=> out_o[0] == ~$past(out_o[0])
			&& (out_o[0] == 11'h7FF || out_o[0] == 11'h000)
	) else $error("word toggle wrong");
	short_noise_a: assert property (
		sample_valid_i && mode == MODE_NOISE_SHORT |=> out_o[0] == {2'h0, $past(short_state)}
	) else $error("short sequence not on output");
	short_hold_a: assert property (
		test_reg[`SHORT_RESET_BIT] |=> short_state == 9'h1FF
	) else $error("short generator not held");
	short_run_a: assert property (
		!test_reg[`SHORT_RESET_BIT] && sample_valid_i && $past(!test_reg[`SHORT_RESET_BIT])
			|=> short_state != $past(short_state)
	) else $error("short generator did not advance");
	long_hold_a: assert property (
		test_reg[`LONG_RESET_BIT] ##1 test_reg[`LONG_RESET_BIT] |-> long_state == 23'h7FFFFF
	) else $error("long generator not held");
	unused_zero_a: assert property (
		sample_valid_i && mode >= 4'h9 && mode <= 4'hE |=> out_o[0] == 11'h000
	) else $error("unused code not zero");
	user_single_a: assert property (
		sample_valid_i && mode == MODE_USER && user_reg == USER_DONE |=> out_o[1] == 11'h000
	) else $error("single pass did not end in zeros");
	user_first_a: assert property (
		sample_valid_i && mode == MODE_USER && user_reg == USER_WORD1
			|=> out_o[0] == $past(user_pattern1_i)
	) else $error("user word 1 not output");
	div_tick_a: assert property (
		div_tick_o && $stable(div_reg) |=> !div_tick_o || div_reg[2:0] == 3'h0
	) else $error("divider tick spacing wrong");
	status_read_a: assert property (
		reg_addr_i == 8'h0A |=> reg_rdata_o == {$past(pll_locked_i), 6'h00, $past(link_ready_i)}
	) else $error("status register read wrong");
endmodule

// ---- verification/adc_test_pattern_and_status_regs_tb.sv ----
`include "adc_test_consts.svh"
module adc_test_pattern_and_status_regs_tb
	import adc_test_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_write_i = 1'b0;
	logic pll_locked_i = 1'b0;
	logic link_ready_i = 1'b0;
	logic sample_valid_i = 1'b0;
	logic [1:0][`SAMPLE_WIDTH-1:0] adc_i = '0;
	sample_type up [4];
	logic [7:0] reg_rdata_o;
	logic out_valid_o;
	logic [1:0][`SAMPLE_WIDTH-1:0] out_o;
	logic [7:0] divider_ratio_o;
	logic div_tick_o;
	int err_total = 0;
	int compares = 0;
	// model state, reset values as after rst_i
	logic [7:0] tc_m = 8'h00;
	logic [7:0] dv_m = 8'h00;
	logic [22:0] lng = '1;
	logic [8:0] sht = '1;
	logic [10:0] ramp = '0;
	bit tog = 1'b0;
	int uidx = 0;
	logic [1:0][`SAMPLE_WIDTH-1:0] exp_out = '0;
	logic [7:0] addrs [5] = '{8'h0A, 8'h0B, 8'h0D, 8'h0C, 8'h00};

	adc_test_pattern_and_status_regs dut_u (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_rdata_o(reg_rdata_o),
		.pll_locked_i(pll_locked_i), .link_ready_i(link_ready_i),
		.sample_valid_i(sample_valid_i), .adc_i(adc_i),
		.user_pattern1_i(up[0]), .user_pattern2_i(up[1]), .user_pattern3_i(up[2]),
		.user_pattern4_i(up[3]), .out_valid_o(out_valid_o), .out_o(out_o),
		.divider_ratio_o(divider_ratio_o), .div_tick_o(div_tick_o)
	);

	initial begin
		forever #5 sys_clk_i = !sys_clk_i;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic sample_type pat(input sample_type a);
		case (tc_m[3:0])
			4'h0: return a;
			4'h1: return `CODE_MIDSCALE;
			4'h2: return `CODE_POS_FULL;
			4'h3: return `CODE_NEG_FULL;
			4'h4: return tog ? `CODE_CHECK_B : `CODE_CHECK_A;
			4'h5: return lng[10:0];
			4'h6: return {2'b00, sht};
			4'h7: return tog ? `CODE_ZEROS : `CODE_ONES;
			4'h8: return (uidx > 3) ? `CODE_ZEROS : up[uidx];
			4'hF: return ramp;
			default: return `CODE_ZEROS;
		endcase
	endfunction

	// one cycle: drive just after an edge, advance model, compare after the next edge
	task automatic step(input logic [7:0] a, input logic [7:0] d, input logic w);
		logic [7:0] exp_rd;
		logic exp_v;
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_write_i = w;
		sample_valid_i = ($urandom % 4) != 0;
		adc_i = {11'($urandom), 11'($urandom)};
		pll_locked_i = 1'($urandom);
		link_ready_i = 1'($urandom);
		exp_rd = (a == 8'h0A) ? {pll_locked_i, 6'h00, link_ready_i} :
			(a == 8'h0B) ? dv_m : (a == 8'h0D) ? tc_m : 8'h00;
		exp_v = sample_valid_i;
		if (sample_valid_i) begin
			exp_out[0] = pat(adc_i[0]);
			exp_out[1] = pat(adc_i[1]);
			tog = !tog;
			ramp = ramp + 11'h001;
			lng = {lng[21:0], lng[22] ^ lng[17]};
			sht = {sht[7:0], sht[8] ^ sht[4]};
			if (uidx < 4)
				uidx = (uidx == 3 && !tc_m[7]) ? 0 : uidx + 1;
		end
		if (tc_m[5])
			lng = '1;
		if (tc_m[4])
			sht = '1;
		if (tc_m[3:0] != 4'h8)
			uidx = 0;
		if (w && a == 8'h0B)
			dv_m = d;
		if (w && a == 8'h0D)
			tc_m = d;
		@(posedge sys_clk_i);
		#1;
		check("reg_rdata_o", 32'(reg_rdata_o), 32'(exp_rd));
		check("out_valid_o", 32'(out_valid_o), 32'(exp_v));
		check("out_o", 32'(out_o), 32'(exp_out));
		check("divider_ratio_o", 32'(divider_ratio_o), 32'(dv_m));
	endtask

	task automatic final_report();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		int ticks;
		logic [7:0] d;
		void'($urandom(32'h51A7B4B1));
		for (int i = 0; i < 4; i++)
			up[i] = 11'($urandom);
		repeat (16) @(posedge sys_clk_i);
		#1;
		rst_i = 1'b0;
		step(8'h0D, 8'h00, 1'b0);
		step(8'h0B, 8'h00, 1'b0);
		// every mode, with both generator resets and both user sequencing choices
		for (int m = 0; m < 16; m++) begin
			for (int v = 0; v < 4; v++) begin
				d = {v[0], 1'b0, v[1], v[1], 4'(m)};
				step(8'h0D, d, 1'b1);
				repeat (12)
					step(addrs[$urandom % 5], 8'(~d), 1'($urandom % 8 == 0));
			end
		end
		// divider: tick once every ratio[2:0]+1 cycles
		for (int n = 0; n < 4; n++) begin
			d = (n == 3) ? 8'($urandom) : {5'($urandom), 3'(n * 3)};
			step(8'h0B, d, 1'b1);
			ticks = 0;
			repeat (8 * (d[2:0] + 1)) begin
				step(8'h0B, 8'h00, 1'b0);
				ticks += int'(div_tick_o === 1'b1);
			end
			check("div_tick_o count", 32'(ticks), 32'd8);
		end
		final_report();
	end

	// run needs about 1000 cycles; the bound leaves wide margin
	initial begin
		#500000;
		err_total++;
		final_report();
	end
endmodule
